// ---- drd_decoder.sv ----
// Dual-bank read-only memory address decoder and bus interface.
// Assumes bus strobes are asynchronous to core_clk; settings are static straps.
//
// Summary of operation
// RQ1 - Low address byte buffered to every socket, valid after the address strobe.
// RQ2 - High address byte captured on the strobe's trailing edge.
// RQ3 - Bank selected when top 4, 3 or 2 bits match its switch.
// RQ4 - Next two bits below compared ones pick one of four chip selects.
// RQ5 - Memory-type setting picks which of three decoders drives selects.
// RQ6 - Bits 10 and 11 routed to sockets by part size.
// RQ7 - Data buffers stay off unless the high address matches the bank.
// RQ8 - Chip selects only produced while the read strobe is active.
// RQ9 - Forced start with link fitted latches bit 15 as one.
// RQ10 - Two independently decoded banks, each 4 to 16 KB in 64 KB.
// RQ11 - One part size per bank; banks configured separately.
// RQ12 - Removed socket link holds that chip select inactive.
// RQ13 - Static settings; no selects outside both configured bank ranges.
`timescale 1ns/1ps
module drd_decoder
	import drd_pkg::*;
#(
	parameter int SYNC_STAGES = 2 // Not used; pin synchronisers are fixed at two stages
) (
	input wire logic core_clk, // Core clock, 100 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic clk_en, // Freezes all state while low
	input wire logic [7:0] bus_addr, // Multiplexed address pins
	input wire logic address_latch_strobe, // Address strobe pin, active high
	input wire logic memory_read_n, // Read strobe pin, active low
	input wire logic forced_high_start, // Forced-start request pin
	input wire logic start_force_link, // Link fitted for forced start
	input wire logic [3:0] bank_a_address_switch, // Bank A base switch
	input wire logic [3:0] bank_b_address_switch, // Bank B base switch
	input wire drd_pkg::drd_size_t bank_a_size, // Bank A part size
	input wire drd_pkg::drd_size_t bank_b_size, // Bank B part size
	input wire logic [3:0] bank_a_socket_links, // Bank A socket enables
	input wire logic [3:0] bank_b_socket_links, // Bank B socket enables
	output logic [7:0] sock_addr_lo, // Low address byte to sockets
	output logic [1:0] bank_a_sock_hi, // Gated bits 11:10, bank A
	output logic [1:0] bank_b_sock_hi, // Gated bits 11:10, bank B
	output logic [3:0] bank_a_cs_n, // Bank A chip selects, active low
	output logic [3:0] bank_b_cs_n, // Bank B chip selects, active low
	output logic data_buf_oe_n, // Both data buffers, low drives bus
	output logic [7:0] hi_addr // Latched high address byte
);
	import drd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage read only by the second
	logic [9:0] sync1_q;
	logic [9:0] sync2_q;
	logic force_s1_q;
	logic force_s2_q;
	logic strobe_d1_q;
	wire logic [9:0] pins = {memory_read_n, address_latch_strobe, bus_addr};
	wire logic [7:0] addr_s = sync2_q[7:0];
	wire logic strobe_s = sync2_q[8];
	wire logic rd_n_s = sync2_q[9];

	// Two-flop synchronisers; memory read reset high (idle)
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= {2'h2, 8'h00};
			sync2_q <= {2'h2, 8'h00};
			force_s1_q <= 1'b0;
			force_s2_q <= 1'b0;
			strobe_d1_q <= 1'b0;
		end else if (clk_en) begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			force_s1_q <= forced_high_start;
			force_s2_q <= force_s1_q;
			strobe_d1_q <= strobe_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trailing edge of the strobe captures the high byte
	wire logic strobe_fall = strobe_d1_q && !strobe_s; // RQ2
	wire logic force_a15 = force_s2_q && start_force_link; // RQ9
	logic [7:0] hi_d;
	assign hi_d = {addr_s[HI_A15] | force_a15, addr_s[6:0]}; // RQ9

	// Sampled bus on the same delay as the strobe, so the byte is coherent
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_addr <= HI_RST;
		end else if (clk_en && strobe_fall) begin
			hi_addr <= hi_d; // RQ2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Two independent bank decoders (RQ10, RQ11)
	logic hit_a;
	logic hit_b;
	logic [3:0] cs_a_n;
	logic [3:0] cs_b_n;
	logic [1:0] sa_a;
	logic [1:0] sa_b;

	drd_bank_dec u_bank_a (
		.hi_addr(hi_addr),
		.bank_sw(bank_a_address_switch),
		.part_size(bank_a_size),
		.sock_links(bank_a_socket_links),
		.rd_n(rd_n_s),
		.bank_hit(hit_a),
		.cs_n(cs_a_n),
		.sock_a(sa_a)
	); // RQ10

	drd_bank_dec u_bank_b (
		.hi_addr(hi_addr),
		.bank_sw(bank_b_address_switch),
		.part_size(bank_b_size),
		.sock_links(bank_b_socket_links),
		.rd_n(rd_n_s),
		.bank_hit(hit_b),
		.cs_n(cs_b_n),
		.sock_a(sa_b)
	); // RQ10 RQ11

	// Buffers enable on a bank match; read strobe sets direction outside
	wire logic buf_en = hit_a || hit_b; // RQ7

	////////////////////////////////////////////////////////////////////////
	// Registered outputs; one cycle behind the decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sock_addr_lo <= 8'h00;
			bank_a_sock_hi <= 2'h0;
			bank_b_sock_hi <= 2'h0;
			bank_a_cs_n <= CS_IDLE_N;
			bank_b_cs_n <= CS_IDLE_N;
			data_buf_oe_n <= 1'b1;
		end else if (clk_en) begin
			sock_addr_lo <= addr_s; // RQ1
			bank_a_sock_hi <= sa_a; // RQ6
			bank_b_sock_hi <= sa_b; // RQ6
			bank_a_cs_n <= cs_a_n; // RQ4 RQ8 RQ12
			bank_b_cs_n <= cs_b_n; // RQ4 RQ8 RQ12
			data_buf_oe_n <= !buf_en; // RQ7
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_latch_on_fall: assert property (clk_en && strobe_fall |=> hi_addr == $past(hi_d)) // RQ2
		else $error("high byte not captured on strobe fall");
	a_hold_no_fall: assert property (!strobe_fall |=> $stable(hi_addr)) // RQ2
		else $error("high byte changed without strobe fall");
	a_force_bit15: assert property (clk_en && strobe_fall && force_a15 |=> hi_addr[HI_A15]) // RQ9
		else $error("forced start did not set bit 15");
	a_cs_need_read: assert property (clk_en && rd_n_s |=> bank_a_cs_n == CS_IDLE_N
		&& bank_b_cs_n == CS_IDLE_N) // RQ8
		else $error("chip select without read");
	a_cs_need_hit: assert property (clk_en && !hit_a |=> bank_a_cs_n == CS_IDLE_N) // RQ3
		else $error("bank A select without match");
	a_cs_link_cut: assert property (clk_en |=> ((~bank_a_cs_n & ~$past(bank_a_socket_links))
		== 4'h0)) // RQ12
		else $error("cut socket selected");
	a_cs_onehot: assert property (clk_en |=> $onehot0(~bank_a_cs_n)) // RQ4
		else $error("more than one select in bank A");
	a_buf_hit: assert property (clk_en |=> data_buf_oe_n == !$past(hit_a || hit_b)) // RQ7
		else $error("data buffer enable mismatch");
	a_low_byte: assert property (clk_en |=> sock_addr_lo == $past(addr_s)) // RQ1
		else $error("low byte not passed");
	a_gate_1k: assert property (clk_en && bank_a_size == DRD_SIZE_1K |=> bank_a_sock_hi == 2'h0) // RQ6
		else $error("1K part got high bits");

	c_read_a: cover property (bank_a_cs_n != CS_IDLE_N);
	c_read_b: cover property (bank_b_cs_n != CS_IDLE_N);
	c_force: cover property (strobe_fall && force_a15);
	c_buf: cover property (!data_buf_oe_n);
endmodule : drd_decoder

// ---- drd_pkg.sv ----
// Package for the dual-bank read-only memory address decoder.
// Assumes a single core clock domain; all users import drd_pkg::*.
package drd_pkg;
	// Widths
	localparam int ADDR_W = 8;
	localparam int SOCK_N = 4;
	// Part size codes held on the memory-type configuration port
	typedef enum logic [1:0] {
		DRD_SIZE_1K,
		DRD_SIZE_2K,
		DRD_SIZE_4K,
		DRD_SIZE_OFF
	} drd_size_t;
	// Bit positions within the latched high byte (address bits 15..8)
	localparam int HI_A10 = 2;
	localparam int HI_A11 = 3;
	localparam int HI_A12 = 4;
	localparam int HI_A13 = 5;
	localparam int HI_A15 = 7;
	// Low two bits of the socket address field carry bits 10 and 11
	localparam int SOCK_A10 = 0;
	localparam int SOCK_A11 = 1;
	// Reset values
	localparam logic [7:0] HI_RST = 8'h00;
	localparam logic [3:0] CS_IDLE_N = 4'hF;
endpackage : drd_pkg

// ---- drd_bank_dec.sv ----
// One bank's compare and two-to-four chip-select decode, purely combinational.
// Assumes a stable latched high byte and static switch settings.
`timescale 1ns/1ps
module drd_bank_dec
	import drd_pkg::*;
(
	input wire logic [7:0] hi_addr, // Latched address bits 15..8
	input wire logic [3:0] bank_sw, // Bank address switch bits
	input wire drd_pkg::drd_size_t part_size, // Memory-type setting
	input wire logic [3:0] sock_links, // High = socket enabled
	input wire logic rd_n, // Synchronised read strobe
	output logic bank_hit, // Address within this bank
	output logic [3:0] cs_n, // Socket chip selects, active low
	output logic [1:0] sock_a // Gated bits 11:10 for sockets
);
	////////////////////////////////////////////////////////////////////////
	// Compare 4, 3 or 2 top bits by part size
	wire logic hit_4k = (hi_addr[7:4] == bank_sw); // RQ3
	wire logic hit_8k = (hi_addr[7:5] == bank_sw[3:1]); // RQ3
	wire logic hit_16k = (hi_addr[7:6] == bank_sw[3:2]); // RQ3
	// Three decoders, one chosen by part size
	wire logic [1:0] sel_4k = hi_addr[HI_A11:HI_A10]; // RQ4
	wire logic [1:0] sel_8k = hi_addr[HI_A12:HI_A11]; // RQ4
	wire logic [1:0] sel_16k = hi_addr[HI_A13:HI_A12]; // RQ4
	logic [1:0] sel;
	logic [3:0] onehot;

	// Decoder selection and bank match (RQ5)
	always_comb begin
		bank_hit = 1'b0;
		sel = sel_4k;
		sock_a = 2'h0;
		case (part_size)
			DRD_SIZE_1K: begin
				bank_hit = hit_4k; // RQ5
				sel = sel_4k;
				sock_a = 2'h0; // RQ6
			end
			DRD_SIZE_2K: begin
				bank_hit = hit_8k; // RQ5
				sel = sel_8k;
				sock_a = {1'b0, hi_addr[HI_A10]}; // RQ6
			end
			DRD_SIZE_4K: begin
				bank_hit = hit_16k; // RQ5
				sel = sel_16k;
				sock_a = hi_addr[HI_A11:HI_A10]; // RQ6
			end
			default: begin
				bank_hit = 1'b0; // RQ13
			end
		endcase
	end

	// Read-qualified decode; cut links and misses keep selects high
	assign onehot = 4'h1 << sel;
	assign cs_n = (bank_hit && !rd_n) ? ~(onehot & sock_links) : CS_IDLE_N; // RQ8 RQ12 RQ13
endmodule : drd_bank_dec

// ---- drd_cpu_model.sv ----
// Backplane processor model: one multiplexed read cycle per go pulse.
// Assumes core_clk drives both this model and the decoder.
`timescale 1ns/1ps
module drd_cpu_model (
	input wire logic core_clk, // Core clock
	input wire logic go, // Start one read cycle
	input wire logic [15:0] addr, // Full address of the cycle
	output logic [7:0] bus_addr, // Multiplexed address pins
	output logic address_latch_strobe, // Address strobe, active high
	output logic memory_read_n // Read strobe, active low
);
	logic [4:0] cnt_q;
	initial begin
		cnt_q = 5'h00;
		bus_addr = 8'h00;
		address_latch_strobe = 1'b0;
		memory_read_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// High byte under a two-cycle strobe, held five cycles past its fall
	always @(posedge core_clk) begin
		if (cnt_q == 5'h00 && go) begin
			cnt_q <= 5'h01;
			bus_addr <= addr[15:8];
		end else if (cnt_q != 5'h00) begin
			cnt_q <= (cnt_q == 5'h16) ? 5'h00 : cnt_q + 5'h01;
		end
		if (cnt_q == 5'h07) begin
			bus_addr <= addr[7:0];
		end
		address_latch_strobe <= (cnt_q == 5'h00 && go) || cnt_q == 5'h01;
		memory_read_n <= !(cnt_q >= 5'h07 && cnt_q < 5'h10);
	end
endmodule : drd_cpu_model

// ---- test_drd_decoder.sv ----
// Bench for the dual-bank decoder: read cycles from the backplane model.
// Assumes drd_pkg, drd_decoder and drd_cpu_model are compiled first.
`timescale 1ns/1ps
module test_drd_decoder;
	import drd_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, go = 1'b0, frc = 1'b0, lnk = 1'b0, ce = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [3:0] a_sw = 4'h0, b_sw = 4'h0, a_lk = 4'hF, b_lk = 4'hF, a_cs, b_cs;
	drd_size_t a_sz = DRD_SIZE_1K, b_sz = DRD_SIZE_1K;
	logic [7:0] bus, lo, hi;
	logic als, rd_n, oe_n;
	logic [1:0] a_hi, b_hi;
	int bad_count = 0, tests_run = 0;
	always #5 core_clk = ~core_clk;
	drd_cpu_model i_cpu (.core_clk(core_clk), .go(go), .addr(addr), .bus_addr(bus),
		.address_latch_strobe(als), .memory_read_n(rd_n));
	drd_decoder i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce), .bus_addr(bus),
		.address_latch_strobe(als), .memory_read_n(rd_n), .forced_high_start(frc),
		.start_force_link(lnk), .bank_a_address_switch(a_sw), .bank_b_address_switch(b_sw),
		.bank_a_size(a_sz), .bank_b_size(b_sz), .bank_a_socket_links(a_lk),
		.bank_b_socket_links(b_lk), .sock_addr_lo(lo), .bank_a_sock_hi(a_hi),
		.bank_b_sock_hi(b_hi), .bank_a_cs_n(a_cs), .bank_b_cs_n(b_cs),
		.data_buf_oe_n(oe_n), .hi_addr(hi));
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Socket address gating expected for a part size
	function automatic logic [1:0] gate(input drd_size_t sz, input logic [7:0] h);
		return (sz == DRD_SIZE_4K) ? h[3:2] : (sz == DRD_SIZE_2K) ? {1'b0, h[2]} : 2'b00;
	endfunction : gate
	// One read cycle; sampled mid-read, then again once the read has ended
	task automatic cycle(input logic [15:0] ad, input logic [7:0] eh, input logic [3:0] eac,
		input logic [3:0] ebc, input logic eoe);
		@(posedge core_clk);
		addr <= ad;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (13) @(posedge core_clk);
		#1;
		chk("hi_addr", eh, hi);
		chk("sock_addr_lo", ad[7:0], lo);
		chk("bank_a_cs_n", {4'h0, eac}, {4'h0, a_cs});
		chk("bank_b_cs_n", {4'h0, ebc}, {4'h0, b_cs});
		chk("data_buf_oe_n", {7'h00, eoe}, {7'h00, oe_n});
		chk("sock_hi", {2'h0, gate(a_sz, eh), 2'h0, gate(b_sz, eh)}, {2'h0, a_hi, 2'h0, b_hi});
		repeat (12) @(posedge core_clk);
		#1;
		chk("idle_cs_n", 8'hFF, {a_cs, b_cs});
	endtask : cycle
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		a_sw <= 4'h9;
		b_sw <= 4'h4;
		b_sz <= DRD_SIZE_4K;
		for (int i = 0; i < 4; i++) begin
			cycle({4'h9, i[1:0], 10'h012}, {4'h9, i[1:0], 2'b00}, ~(4'h1 << i), 4'hF, 1'b0);
		end
		cycle(16'h7C34, 8'h7C, 4'hF, 4'h7, 1'b0);
		@(posedge core_clk);
		a_sz <= DRD_SIZE_2K;
		a_sw <= 4'hA;
		b_lk <= 4'h7;
		cycle(16'hAC56, 8'hAC, 4'hD, 4'hF, 1'b0);
		cycle(16'h7C34, 8'h7C, 4'hF, 4'hF, 1'b0);
		cycle(16'h0000, 8'h00, 4'hF, 4'hF, 1'b1);
		// Bank B switched off: an address it would otherwise own stays unselected
		@(posedge core_clk);
		b_sz <= DRD_SIZE_OFF;
		cycle(16'h4012, 8'h40, 4'hF, 4'hF, 1'b1);
		@(posedge core_clk);
		a_sz <= DRD_SIZE_1K;
		a_sw <= 4'h9;
		frc <= 1'b1;
		lnk <= 1'b1;
		cycle(16'h1C00, 8'h9C, 4'h7, 4'hF, 1'b0);
		@(posedge core_clk);
		lnk <= 1'b0;
		cycle(16'h1C00, 8'h1C, 4'hF, 4'hF, 1'b1);
		// Clock enable low: a read that would hit bank A must leave no trace
		@(posedge core_clk);
		ce <= 1'b0;
		addr <= 16'h9455;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (25) @(posedge core_clk);
		#1;
		chk("frozen_hi_addr", 8'h1C, hi);
		chk("frozen_lo", 8'h00, lo);
		chk("frozen_cs_n", 8'hFF, {a_cs, b_cs});
		@(posedge core_clk);
		ce <= 1'b1;
		@(posedge core_clk);
		finish_test();
	end
	// Guard against a hung run
	initial begin
		repeat (2000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end
endmodule : test_drd_decoder
